// File: rtl/off_request_reset_controller.sv
// Off request reset controller with power sequencing and AXI4-Lite registers
//
// The register offsets and the AXI4-Lite slave port are this design's own decisions.
`timescale 1ns/100ps
module off_request_reset_controller #(
  parameter int DLY_UNIT = off_ctrl_pkg::DLY_UNIT_CYC,
  parameter int SLOT = off_ctrl_pkg::SLOT_CYC
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] off_src,
  input wire logic on_req,
  input wire logic sleep_req,
  input wire logic wake_req,
  input wire logic on_gate,
  output logic [off_ctrl_pkg::RAILS-1:0] rail_en,
  output logic [2:0] power_state,
  output logic full_hard_reset,
  output logic switch_off_reset,
  output logic watchdog_run,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);
  off_ctrl_pkg::state_s s_q, s_d;
  off_ctrl_pkg::events_s ev;

  // Byte-lane merge of a write into an old word
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] be);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++)
      if (be[i])
        r[i*8 +: 8] = nw[i*8 +: 8];
    return r;
  endfunction

  // Switch-off delay code to cycles; code 0 gives none
  function automatic logic [31:0] delay_cycles(input logic [1:0] code);
    return 32'(code) * 32'(DLY_UNIT);
  endfunction

  // Every off and control pin is seen only through its two synchroniser flops
  assign ev = {s_q.sync2, s_q.ctl2};

  // Rails, resets and read data straight from state flops; power state, watchdog and handshakes are combinational decodes
  assign rail_en = s_q.en;
  assign power_state = {s_q.st == off_ctrl_pkg::ST_SLEEP, s_q.st == off_ctrl_pkg::ST_ACTIVE,
                        s_q.st == off_ctrl_pkg::ST_OFF};
  assign full_hard_reset = s_q.full_rst;
  assign switch_off_reset = s_q.swo_rst;
  assign watchdog_run = (s_q.st == off_ctrl_pkg::ST_ACTIVE) ||
                        (s_q.st == off_ctrl_pkg::ST_SLEEP && !s_q.cfg[off_ctrl_pkg::CFG_WD_HOLD]);
  assign s_axi_awready = !s_q.aw_ok && !s_q.bvalid;
  assign s_axi_wready = !s_q.w_ok && !s_q.bvalid;
  assign s_axi_bvalid = s_q.bvalid;
  assign s_axi_bresp = s_q.bresp;
  assign s_axi_arready = !s_q.rvalid;
  assign s_axi_rvalid = s_q.rvalid;
  assign s_axi_rdata = s_q.rdata;
  assign s_axi_rresp = s_q.rresp;

  ////////////////////////////////////////////////////////////////////////////
  // Next-state logic
  always_comb
  begin
    logic [7:0] hit;
    logic take;
    int src;
    logic [3:0] slot_of;
    logic [31:0] wv;
    logic device_on_bit_set;
    logic fin;
    s_d = s_q;
    hit = 8'h00;
    take = 1'b0;
    src = 0;
    slot_of = 4'h0;
    wv = 32'h0000_0000;
    device_on_bit_set = 1'b0;
    fin = 1'b0;
    s_d.full_rst = 1'b0;
    s_d.swo_rst = 1'b0;
    // Pin synchroniser, first stage read only by the second
    s_d.sync1 = off_src;
    s_d.sync2 = s_q.sync1;
    s_d.ctl1 = {on_req, sleep_req, wake_req, on_gate};
    s_d.ctl2 = s_q.ctl1;
    hit = ev.req;
    hit[off_ctrl_pkg::SRC_SW_RESET] = ev.req[off_ctrl_pkg::SRC_SW_RESET] | s_q.cfg[off_ctrl_pkg::CFG_SW_RESET];
    s_d.cfg[off_ctrl_pkg::CFG_SW_RESET] = 1'b0;

    // Lowest numbered active source wins
    for (int i = 7; i >= 0; i--)
      if (hit[i])
        src = i;

    // Power state machine
    case (s_q.st)
      off_ctrl_pkg::ST_OFF:
      begin
        s_d.en = '0;
        if (ev.on_req && !ev.on_gate)
        begin
          s_d.st = off_ctrl_pkg::ST_UP;
          s_d.slot = 4'h0;
          s_d.cnt = 32'(SLOT);
        end
      end
      off_ctrl_pkg::ST_UP:
      begin
        // Each rail enables once its slot instant is passed
        for (int r = 0; r < off_ctrl_pkg::RAILS; r++)
        begin
          slot_of = off_ctrl_pkg::UP_SLOTS[r*4 +: 4];
          if (slot_of <= s_q.slot)
            s_d.en[r] = 1'b1;
        end
        if (s_q.cnt > 32'h1)
          s_d.cnt = s_q.cnt - 32'h1;
        else if (s_q.slot == 4'hE)
        begin
          s_d.st = off_ctrl_pkg::ST_ACTIVE;
          if (s_q.cfg[off_ctrl_pkg::CFG_AUTO_ON])
            device_on_bit_set = 1'b1;
        end
        else
        begin
          s_d.slot = s_q.slot + 4'h1;
          s_d.cnt = 32'(SLOT);
        end
      end
      off_ctrl_pkg::ST_ACTIVE, off_ctrl_pkg::ST_SLEEP:
      begin
        if (s_q.st == off_ctrl_pkg::ST_ACTIVE && ev.sleep_req)
          s_d.st = off_ctrl_pkg::ST_SLEEP;
        if (s_q.st == off_ctrl_pkg::ST_SLEEP && ev.wake_req)
          s_d.st = off_ctrl_pkg::ST_ACTIVE;
        if (|hit)
        begin
          take = 1'b1;
          s_d.held_depth = s_q.depth[src];
          s_d.held_restart = s_q.restart[src];
          s_d.held_fast = (src == off_ctrl_pkg::SRC_PDN_PIN && s_q.cfg[off_ctrl_pkg::CFG_PIN_FAST]) ||
                          (src == off_ctrl_pkg::SRC_THERMAL && s_q.cfg[off_ctrl_pkg::CFG_THERM_FAST]);
          s_d.cnt = delay_cycles(s_q.cfg[off_ctrl_pkg::CFG_DLY_LO +: 2]);
          // Fast-off skips both delay and ordered shutdown
          if (s_d.held_fast)
          begin
            s_d.en = '0;
            s_d.st = off_ctrl_pkg::ST_DOWN;
            s_d.slot = 4'h0;
            s_d.cnt = 32'h0;
          end
          else if (s_q.st == off_ctrl_pkg::ST_ACTIVE && s_d.cnt != 32'h0)
            s_d.st = off_ctrl_pkg::ST_DELAY;
          else
          begin
            s_d.st = off_ctrl_pkg::ST_DOWN;
            s_d.slot = 4'hE;
            s_d.cnt = 32'(SLOT);
          end
        end
      end
      off_ctrl_pkg::ST_DELAY:
      begin
        // Host keeps running to save context; new requests ignored
        if (s_q.cnt > 32'h1)
          s_d.cnt = s_q.cnt - 32'h1;
        else
        begin
          s_d.st = off_ctrl_pkg::ST_DOWN;
          s_d.slot = 4'hE;
          s_d.cnt = 32'(SLOT);
        end
      end
      off_ctrl_pkg::ST_DOWN:
      begin
        // Reverse order of power-up: latest rails drop first
        for (int r = 0; r < off_ctrl_pkg::RAILS; r++)
        begin
          slot_of = off_ctrl_pkg::UP_SLOTS[r*4 +: 4];
          if (slot_of >= s_q.slot)
            s_d.en[r] = 1'b0;
        end
        if (s_q.cnt > 32'h1)
          s_d.cnt = s_q.cnt - 32'h1;
        else if (s_q.slot != 4'h0)
        begin
          s_d.slot = s_q.slot - 4'h1;
          s_d.cnt = 32'(SLOT);
        end
        else
        begin
          s_d.en = '0;
          fin = 1'b1;
          // Reset domain pulse; full reset covers switch-off domain too
          s_d.full_rst = s_q.held_depth;
          s_d.swo_rst = 1'b1;
          s_d.rail = off_ctrl_pkg::RST_RAIL;
          s_d.cfg[off_ctrl_pkg::CFG_DEVICE_ON_BIT] = 1'b0;
          if (s_q.held_depth)
          begin
            s_d.depth = off_ctrl_pkg::RST_DEPTH;
            s_d.restart = off_ctrl_pkg::RST_RESTART;
            s_d.cfg = off_ctrl_pkg::RST_CONFIG;
          end
          if (s_q.held_restart && !ev.on_gate)
          begin
            s_d.st = off_ctrl_pkg::ST_UP;
            s_d.slot = 4'h0;
            s_d.cnt = 32'(SLOT);
          end
          else
            s_d.st = off_ctrl_pkg::ST_OFF;
        end
      end
      default:
        s_d.st = off_ctrl_pkg::ST_OFF;
    endcase

    ////////////////////////////////////////////////////////////////////////////
    // AXI4-Lite write: address and data in either order
    if (s_axi_awvalid && s_axi_awready)
    begin
      s_d.aw_ok = 1'b1;
      s_d.awaddr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready)
    begin
      s_d.w_ok = 1'b1;
      s_d.wdata = s_axi_wdata;
      s_d.wstrb = s_axi_wstrb;
    end
    if (s_q.aw_ok && s_q.w_ok)
    begin
      s_d.aw_ok = 1'b0;
      s_d.w_ok = 1'b0;
      s_d.bvalid = 1'b1;
      s_d.bresp = off_ctrl_pkg::RESP_OKAY;
      case (s_q.awaddr)
        off_ctrl_pkg::OFS_DEPTH:
        begin
          wv = merge({24'h0, s_q.depth}, s_q.wdata, s_q.wstrb);
          if (!take && !fin)
            s_d.depth = wv[7:0];
        end
        off_ctrl_pkg::OFS_RESTART:
        begin
          wv = merge({24'h0, s_q.restart}, s_q.wdata, s_q.wstrb);
          if (!take && !fin)
            s_d.restart = wv[7:0];
        end
        off_ctrl_pkg::OFS_CONFIG:
        begin
          wv = merge({24'h0, s_q.cfg}, s_q.wdata, s_q.wstrb);
          if (!fin)
            s_d.cfg = wv[7:0];
        end
        off_ctrl_pkg::OFS_RAIL:
          if (!fin) // Reset at end of power-down beats a write
            s_d.rail = merge(s_q.rail, s_q.wdata, s_q.wstrb);
        default:
          s_d.bresp = off_ctrl_pkg::RESP_SLVERR;
      endcase
    end
    if (s_q.bvalid && s_axi_bready)
      s_d.bvalid = 1'b0;
    // Hardware set of device-on wins over a same-cycle write
    if (device_on_bit_set)
      s_d.cfg[off_ctrl_pkg::CFG_DEVICE_ON_BIT] = 1'b1;

    // AXI4-Lite read, data one cycle after the address
    if (s_axi_arvalid && !s_q.rvalid)
    begin
      s_d.rvalid = 1'b1;
      s_d.rresp = off_ctrl_pkg::RESP_OKAY;
      case (s_axi_araddr)
        off_ctrl_pkg::OFS_DEPTH: s_d.rdata = {24'h0, s_q.depth};
        off_ctrl_pkg::OFS_RESTART: s_d.rdata = {24'h0, s_q.restart};
        off_ctrl_pkg::OFS_CONFIG: s_d.rdata = {24'h0, s_q.cfg};
        off_ctrl_pkg::OFS_RAIL: s_d.rdata = s_q.rail;
        off_ctrl_pkg::OFS_STATUS: s_d.rdata = {7'h00, s_q.st, s_q.slot, s_q.en};
        default:
        begin
          s_d.rdata = 32'h0000_0000;
          s_d.rresp = off_ctrl_pkg::RESP_SLVERR;
        end
      endcase
    end
    else if (s_q.rvalid && s_axi_rready)
      s_d.rvalid = 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////////
  // State register, synchronous reset
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_q <= '0;
      s_q.st <= off_ctrl_pkg::ST_OFF;
      s_q.depth <= off_ctrl_pkg::RST_DEPTH;
      s_q.restart <= off_ctrl_pkg::RST_RESTART;
      s_q.cfg <= off_ctrl_pkg::RST_CONFIG;
      s_q.rail <= off_ctrl_pkg::RST_RAIL;
    end
    else
      s_q <= s_d;
  end
endmodule

// File: rtl/off_ctrl_pkg.sv
// Package of constants and carriers for the off request reset controller
package off_ctrl_pkg;
  // Off source bit positions
  localparam int SRC_LONG_PRESS = 0;
  localparam int SRC_PDN_PIN = 1;
  localparam int SRC_WATCHDOG = 2;
  localparam int SRC_THERMAL = 3;
  localparam int SRC_RESET_IN = 4;
  localparam int SRC_SW_RESET = 5;
  localparam int SRC_SUPPLY_LOW = 6;
  localparam int SRC_CONVERTER = 7;
  // Register byte offsets
  localparam logic [7:0] OFS_DEPTH = 8'h00;
  localparam logic [7:0] OFS_RESTART = 8'h04;
  localparam logic [7:0] OFS_CONFIG = 8'h08;
  localparam logic [7:0] OFS_RAIL = 8'h0C;
  localparam logic [7:0] OFS_STATUS = 8'h10;
  // Config field positions
  localparam int CFG_DLY_LO = 0;
  localparam int CFG_AUTO_ON = 2;
  localparam int CFG_PIN_FAST = 3;
  localparam int CFG_THERM_FAST = 4;
  localparam int CFG_WD_HOLD = 5;
  localparam int CFG_DEVICE_ON_BIT = 6;
  localparam int CFG_SW_RESET = 7;
  // Reset values
  localparam logic [7:0] RST_DEPTH = 8'h7D;
  localparam logic [7:0] RST_RESTART = 8'h24;
  localparam logic [7:0] RST_CONFIG = 8'h00;
  localparam logic [31:0] RST_RAIL = 32'h0000_0000;
  // Timing
  localparam int CLK_HZ = 10_000_000;
  localparam int SLOT_US = 550;
  localparam int SLOT_CYC = SLOT_US * (CLK_HZ / 1_000_000);
  localparam int RAILS = 15;
  localparam int DLY_UNIT_US = 1000;
  localparam int DLY_UNIT_CYC = DLY_UNIT_US * (CLK_HZ / 1_000_000);
  // Power-up slot of each rail, in 550 us units, step 1 at 0.55 ms, last 7.15 ms
  localparam logic [15*4-1:0] UP_SLOTS = 60'hDDC_BA99_7555_4211;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [5:0] {
    ST_OFF = 6'h01,
    ST_UP = 6'h02,
    ST_ACTIVE = 6'h04,
    ST_SLEEP = 6'h08,
    ST_DELAY = 6'h10,
    ST_DOWN = 6'h20
  } pstate_e;

  typedef struct packed {
    logic [7:0] req;
    logic on_req;
    logic sleep_req;
    logic wake_req;
    logic on_gate;
  } events_s;

  typedef struct packed {
    pstate_e st;
    logic [7:0] depth;
    logic [7:0] restart;
    logic [7:0] cfg;
    logic [31:0] rail;
    logic [RAILS-1:0] en;
    logic [3:0] slot;
    logic [31:0] cnt;
    logic held_depth;
    logic held_restart;
    logic held_fast;
    logic full_rst;
    logic swo_rst;
    logic [7:0] sync1;
    logic [7:0] sync2;
    logic [3:0] ctl1;
    logic [3:0] ctl2;
    logic aw_ok;
    logic w_ok;
    logic [7:0] awaddr;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } state_s;
endpackage

// File: verification/off_ctrl_asserts.sv
// Port checker of the off request reset controller
`timescale 1ns/100ps
module off_ctrl_asserts #(
  parameter int DLY_UNIT = 4,
  parameter int SLOT = 3
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] off_src,
  input wire logic [off_ctrl_pkg::RAILS-1:0] rail_en,
  input wire logic [2:0] power_state,
  input wire logic full_hard_reset,
  input wire logic switch_off_reset,
  input wire logic watchdog_run,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid
);
  // Sync and decode slack; the delay state already counts as leaving ACTIVE
  localparam int MAXD = 8;
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  ////////////////////////////////////////////////////////////////////////
  // Power state and rails
  a_off_dark: assert property (power_state == 3'b001 |-> rail_en == '0)
    else $error("rails lit while off");
  a_active_lit: assert property (power_state == 3'b010 |-> &rail_en)
    else $error("rail dark while active");
  a_leave_active: assert property (power_state == 3'b010 && off_src != 8'h00 |-> ##[1:MAXD] power_state != 3'b010)
    else $error("off request left device active");
  a_wd_active: assert property (power_state == 3'b010 |-> watchdog_run)
    else $error("watchdog stopped while active");
  // Reset pulses close every power-down; then read answer timing and covers
  a_full_with_swo: assert property (full_hard_reset |-> switch_off_reset)
    else $error("full reset without switch-off pulse");
  a_swo_pulse: assert property (switch_off_reset |=> !switch_off_reset)
    else $error("reset pulse longer than a cycle");
  a_swo_dark: assert property (switch_off_reset |-> rail_en == '0)
    else $error("reset pulse before rails dropped");
  a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read not answered next cycle");
  c_full: cover property (full_hard_reset);
  c_swo_only: cover property (switch_off_reset && !full_hard_reset);
  c_sleep: cover property (power_state == 3'b100);
endmodule
bind off_request_reset_controller off_ctrl_asserts #(.DLY_UNIT(DLY_UNIT), .SLOT(SLOT)) off_ctrl_asserts_i (
  .aclk, .aresetn, .off_src, .rail_en, .power_state, .full_hard_reset, .switch_off_reset,
  .watchdog_run, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid);

// File: verification/host_rails_model.sv
// Host side model raising on, sleep and wake requests
`timescale 1ns/100ps
module host_rails_model (
  input wire logic aclk,
  input wire logic want_on,
  input wire logic want_sleep,
  input wire logic [2:0] power_state,
  output logic on_req,
  output logic sleep_req,
  output logic wake_req
);
  // Quiet at time zero so reset sees no request
  initial {on_req, sleep_req, wake_req} = 3'b000;
  // Each request drops once the state answers, so a halt is not undone
  always @(posedge aclk)
  begin
    on_req <= want_on && power_state == 3'b001;
    sleep_req <= want_sleep && power_state == 3'b010;
    wake_req <= !want_sleep && power_state == 3'b100;
  end
endmodule

// File: verification/tb_off_request_reset_controller.sv
// Self-checking bench of the off request reset controller
`timescale 1ns/100ps
module tb_off_request_reset_controller;
  localparam int DU = 4;
  localparam int SL = 3;
  logic aclk, aresetn, on_req, sleep_req, wake_req, on_gate, want_on, want_sleep, fhr, swr, wd_run;
  logic awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
  logic [7:0] off_src, awaddr, araddr;
  logic [14:0] rail_en;
  logic [2:0] power_state;
  logic [31:0] wdata, rdata, rd;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp, rs;
  int fail_count, cmp_count;
  off_request_reset_controller #(.DLY_UNIT(DU), .SLOT(SL)) off_request_reset_controller_i (
    .aclk(aclk), .aresetn(aresetn), .off_src(off_src), .on_req(on_req), .sleep_req(sleep_req),
    .wake_req(wake_req), .on_gate(on_gate), .rail_en(rail_en), .power_state(power_state),
    .full_hard_reset(fhr), .switch_off_reset(swr), .watchdog_run(wd_run),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready));
  host_rails_model host_rails_model_i (.aclk, .want_on, .want_sleep, .power_state, .on_req, .sleep_req, .wake_req);
  ////////////////////////////////////////////////////////////////////////
  // Compare and count
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    cmp_count++;
    if (g !== e)
    begin
      fail_count++;
      $display("[FAIL] %s expected %h seen %h", n, e, g);
    end
  endtask
  // Bus write, both channels offered together
  task automatic axw(input logic [7:0] a, input logic [31:0] d);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
    end while (bvalid !== 1'b1);
    rs = bresp;
  endtask
  // Bus read and check of data and response
  task automatic rchk(input logic [7:0] a, input logic [31:0] e, input logic [1:0] r);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (arvalid && arready) arvalid <= 1'b0;
    end while (rvalid !== 1'b1);
    chk("rdata", e, rdata);
    chk("rresp", {30'h0, r}, {30'h0, rresp});
  endtask
  // Bounded wait for a power state
  task automatic wait_ps(input logic [2:0] s);
    int n;
    n = 0;
    while (power_state !== s && n < 400)
    begin
      @(posedge aclk);
      n++;
    end
    chk("power_state", {29'h0, s}, {29'h0, power_state});
  endtask
  task automatic go_active;
    want_on <= 1'b1;
    @(posedge aclk);
    wait_ps(3'b010);
    chk("rail_en", 32'h0000_7FFF, {17'h0, rail_en});
    want_on <= 1'b0;
  endtask
  // One off request with chosen depth, restart, gating and options
  task automatic off_run(input int src, input logic dep, input logic rst, input logic gate, input logic [7:0] cfg);
    logic [7:0] dv, cv;
    logic fast;
    int n;
    dv = 8'($urandom);
    dv[src] = dep;
    cv = 8'($urandom);
    cv[src] = rst;
    fast = (src == 1 && cfg[3]) || (src == 3 && cfg[4]);
    axw(off_ctrl_pkg::OFS_DEPTH, {24'h0, dv});
    axw(off_ctrl_pkg::OFS_RESTART, {24'h0, cv});
    axw(off_ctrl_pkg::OFS_CONFIG, {24'h0, cfg});
    axw(off_ctrl_pkg::OFS_RAIL, 32'h5A5A_A5A5);
    on_gate <= gate;
    off_src[src] <= 1'b1;
    n = 0;
    while (swr !== 1'b1 && n < 400)
    begin
      @(posedge aclk);
      n++;
    end
    off_src[src] <= 1'b0;
    chk("switch_off_reset", 1, swr);
    chk("full_hard_reset", dep, fhr);
    if (fast) chk("fast_off_cycles", 32'd5, n);
    else chk("sequenced_cycles", 32'(cfg[1:0]) * DU + 15 * SL + 4, n);
    if (rst && !gate) wait_ps(3'b010);
    else wait_ps(3'b001);
    on_gate <= 1'b0;
    repeat (3 * SL) @(posedge aclk);
    chk("state_held", (rst && !gate) ? 32'h2 : 32'h1, {29'h0, power_state});
    chk("rail_en_held", (rst && !gate) ? 32'h0000_7FFF : 32'h0, {17'h0, rail_en});
    rchk(off_ctrl_pkg::OFS_RAIL, 32'h0, off_ctrl_pkg::RESP_OKAY);
    rchk(off_ctrl_pkg::OFS_STATUS, (rst && !gate) ? 32'h0027_7FFF : 32'h0008_0000, 2'h0);
    rchk(off_ctrl_pkg::OFS_DEPTH, dep ? 32'h7D : {24'h0, dv}, off_ctrl_pkg::RESP_OKAY);
    rchk(off_ctrl_pkg::OFS_CONFIG, dep ? 32'h0 : {25'h0, cfg[2] && rst && !gate, cfg[5:0]}, 2'h0);
  endtask
  task automatic print_verdict;
    if (fail_count == 0 && cmp_count > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////
  // 10 MHz clock
  initial
  begin
    aclk = 1'b0;
    forever #50 aclk = ~aclk;
  end
  // Hang guard, far beyond the expected few thousand cycles
  initial
  begin
    repeat (20000) @(posedge aclk);
    fail_count++;
    print_verdict();
  end
  // Main sequence
  initial
  begin
    {aresetn, on_gate, want_on, want_sleep, awvalid, wvalid, bready, arvalid, rready} = '0;
    {off_src, awaddr, araddr, wdata} = '0;
    wstrb = 4'hF;
    void'($urandom(32'h195D1B13));
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    rchk(off_ctrl_pkg::OFS_DEPTH, 32'h7D, off_ctrl_pkg::RESP_OKAY);
    rchk(off_ctrl_pkg::OFS_RESTART, 32'h24, off_ctrl_pkg::RESP_OKAY);
    rchk(off_ctrl_pkg::OFS_CONFIG, 32'h0, off_ctrl_pkg::RESP_OKAY);
    rchk(8'h20, 32'h0, off_ctrl_pkg::RESP_SLVERR);
    axw(8'h24, 32'h1);
    chk("bresp", {30'h0, off_ctrl_pkg::RESP_SLVERR}, {30'h0, rs});
    // Sleep keeps the watchdog unless held, then a full reset from sleep
    go_active();
    want_sleep <= 1'b1;
    wait_ps(3'b100);
    chk("watchdog_run", 1, wd_run);
    axw(off_ctrl_pkg::OFS_CONFIG, 32'h20);
    repeat (2) @(posedge aclk);
    chk("watchdog_run", 0, wd_run);
    off_run(0, 1'b1, 1'b0, 1'b0, 8'h20);
    want_sleep <= 1'b0;
    // Every source once, then fast-off cases and random sources
    for (int i = 0; i < 14; i++)
    begin
      go_active();
      if (i == 8) off_run(1, 1'($urandom), 1'($urandom), 1'($urandom), 8'h08);
      else if (i == 9) off_run(3, 1'($urandom), 1'($urandom), 1'($urandom), 8'h10);
      else off_run(i < 8 ? i : int'($urandom % 8), 1'($urandom), 1'($urandom), 1'($urandom),
                   8'($urandom & 8'h27));
    end
    print_verdict();
  end
endmodule
